// file: dv/tb_io_port_watchdog_timer.sv
module tb_io_port_watchdog_timer;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TP = 4;
  logic i_clk_sys = 0;
  logic i_rstn = 0;
  logic o_running;
  logic o_sys_reset_req;
  logic [7:0] o_rdata;
  logic [7:0] o_remaining;
  wdt_pkg::io_req_t i_io = '0;
  int fails;
  int check_count;
  int n;
  always #5 i_clk_sys = ~i_clk_sys;
  io_port_watchdog_timer #(.TICK_PERIOD(TP)) u_dut (.*);
  task automatic chk(string s, logic [7:0] exp, logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", s, exp, got);
    end
  endtask
  // one access strobe, then one idle cycle so that calls never overlap
  task automatic io(logic [15:0] a, logic [7:0] d, logic w);
    i_io <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge i_clk_sys) #1;
    i_io <= '0;
    @(posedge i_clk_sys) #1;
  endtask
  task automatic final_report;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge i_clk_sys);
    #1 i_rstn = 1;
    chk("running_rst", 8'h00, {7'h00, o_running});
    io(16'h0443, 8'h02, 1'b1);
    chk("remaining", 8'h02, o_remaining);
    chk("running", 8'h01, {7'h00, o_running});
    repeat (5) @(posedge i_clk_sys) #1;
    chk("remaining_1s", 8'h01, o_remaining);
    io(16'h0443, 8'h02, 1'b1);
    chk("remaining_rl", 8'h02, o_remaining);
    // without the refresh the pulse would have come at the last clock edge
    for (n = 0; n < 12 && o_sys_reset_req !== 1'b1; n++) @(posedge i_clk_sys) #1;
    chk("fire_wait", 8'(2 * TP - 1), 8'(n));
    if (n == 12) final_report();
    chk("running_exp", 8'h00, {7'h00, o_running});
    chk("remaining_exp", 8'h00, o_remaining);
    @(posedge i_clk_sys) #1;
    chk("pulse_len", 8'h00, {7'h00, o_sys_reset_req});
    io(16'h0444, 8'h05, 1'b1);
    chk("running_other", 8'h00, {7'h00, o_running});
    io(16'h0443, 8'h01, 1'b1);
    chk("running_1", 8'h01, {7'h00, o_running});
    io(16'h0043, 8'h00, 1'b0);
    chk("rdata", 8'h00, o_rdata);
    chk("running_dis", 8'h00, {7'h00, o_running});
    repeat (8) begin
      @(posedge i_clk_sys) #1;
      chk("pulse_off", 8'h00, {7'h00, o_sys_reset_req});
    end
    io(16'h0443, 8'h03, 1'b1);
    i_rstn = 0;
    @(posedge i_clk_sys) #1;
    i_rstn = 1;
    chk("running_rst2", 8'h00, {7'h00, o_running});
    chk("remaining_rst2", 8'h00, o_remaining);
    final_report();
  end
endmodule
bind io_port_watchdog_timer wdt_props u_props (.*);

// file: dv/wdt_props.sv
module wdt_props (input wire logic i_clk_sys, i_rstn, o_running, o_sys_reset_req,
  input wire wdt_pkg::io_req_t i_io);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  // a zero code disarms, so only nonzero loads must arm
  wire ld = i_io.wr && i_io.addr == 16'h0443 && |i_io.wdata;
  wire rd = i_io.rd && i_io.addr == 16'h0043;
  a_load_arms: assert property (ld |=> o_running) else $error("arm");
  a_read_stops: assert property (rd |=> !o_running) else $error("off");
  a_idle_quiet: assert property (!o_running |=> !o_sys_reset_req) else $error("idle");
  a_one_pulse: assert property (o_sys_reset_req |=> !o_sys_reset_req) else $error("len");
  a_pulse_halts: assert property (o_sys_reset_req |-> !o_running) else $error("run");
  cover property (ld);
  cover property (rd);
  cover property (o_sys_reset_req);
endmodule

// file: hdl/io_port_watchdog_timer.sv
module io_port_watchdog_timer #(
  parameter int TICK_PERIOD = wdt_pkg::TICK_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire wdt_pkg::io_req_t i_io,
  output logic [7:0] o_rdata,
  output logic o_running,
  output logic [7:0] o_remaining,
  output logic o_sys_reset_req
);
  import wdt_pkg::*;

  // operating states of the watchdog
  // the spare code 2'b11 cannot be reached; should it appear it falls back to off
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_RUN = 2'b01,
    ST_FIRE = 2'b10
  } wdt_state_t;

  // elaboration checks: the tick needs at least one cycle per second,
  // and the two ports must decode apart, else one address would serve both load and disable
  generate
    if (TICK_PERIOD < 1) begin : g_bad_period
      $error("tick period must be at least one cycle");
    end
    if (LOAD_PORT == DISABLE_PORT) begin : g_bad_ports
      $error("load and disable ports must differ");
    end
  endgenerate

  // state register and its next value
  wdt_state_t state_q;
  wdt_state_t state_d;

  // seconds left in the current interval
  logic [7:0] count_q;
  logic [7:0] count_d;

  // registered status and request outputs
  logic run_q;
  logic run_d;
  logic rst_req_q;
  logic rst_req_d;

  // read data of the disable port
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // one-second strobe from the prescaler
  logic tick;
  logic tick_restart;

  // address decode
  wire logic addr_is_load = (i_io.addr == LOAD_PORT);
  wire logic addr_is_disable = (i_io.addr == DISABLE_PORT);

  // access strobes that hit one of the two ports
  wire logic load_hit = i_io.wr && addr_is_load;
  wire logic disable_hit = i_io.rd && addr_is_disable;

  // a code of zero would mean no time at all, so it is treated as a disable
  wire logic code_zero = (i_io.wdata == 8'h00);
  wire logic load_ok = load_hit && !code_zero;

  // state decode
  wire logic is_off = (state_q == ST_OFF);
  wire logic is_run = (state_q == ST_RUN);
  wire logic is_fire = (state_q == ST_FIRE);

  // countdown controls
  wire logic count_last = (count_q == 8'h01);
  wire logic count_step = is_run && tick;
  wire logic expire = count_step && count_last;

  // the prescaler is held while stopped and realigned by every load,
  // so the first second after a load is always a whole second
  assign tick_restart = load_hit || !is_run;

  wdt_tick #(
    .PERIOD(TICK_PERIOD)
  ) u_tick (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_restart(tick_restart),
    .o_tick(tick)
  );

  // next state
  // load wins over a same-cycle disable read: the newer intent is to keep running;
  // a load write or a disable read in the expiry cycle cancels the reset request
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_OFF: begin
        if (load_ok) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (load_hit) begin
          state_d = load_ok ? ST_RUN : ST_OFF;
        end else if (disable_hit) begin
          state_d = ST_OFF;
        end else if (expire) begin
          state_d = ST_FIRE;
        end
      end
      ST_FIRE: begin
        if (load_ok) begin
          state_d = ST_RUN;
        end else begin
          state_d = ST_OFF;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
  end

  // the written code is the number of whole seconds to run
  assign count_d = load_hit ? i_io.wdata :
                   count_step ? count_q - 8'h01 :
                   count_q;

  // outputs follow the next state so they change together with it
  assign run_d = (state_d == ST_RUN);
  assign rst_req_d = (state_d == ST_FIRE);

  // the disable port has no contents of its own; a read returns the idle value
  assign rdata_d = RD_DATA_IDLE;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      count_q <= COUNT_RESET;
    end else begin
      count_q <= count_d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      run_q <= 1'b0;
    end else begin
      run_q <= run_d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      rst_req_q <= 1'b0;
    end else begin
      rst_req_q <= rst_req_d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      rdata_q <= RD_DATA_IDLE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // status decode kept for a debug view; unused states cost nothing here
  wire logic state_known = is_off || is_run || is_fire;
  wire logic unused_ok = state_known;

  assign o_rdata = rdata_q;
  assign o_running = run_q;
  assign o_remaining = count_q;
  assign o_sys_reset_req = rst_req_q;
endmodule

// file: hdl/wdt_tick.sv
// one-cycle pulse every period; restart realigns it so the first second is whole
module wdt_tick #(
  parameter int PERIOD = 100000000
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_restart,
  output logic o_tick
);
  localparam int W = $clog2(PERIOD + 1);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  wire logic at_end = (cnt_q == W'(PERIOD - 1));

  generate
    if (PERIOD < 1) begin : g_bad_period
      $error("tick period must be at least one cycle");
    end
  endgenerate

  assign cnt_d = (i_restart || at_end) ? '0 : cnt_q + W'(1);
  assign o_tick = at_end && !i_restart;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) cnt_q <= '0;
    else cnt_q <= cnt_d;
  end
endmodule

// file: include/wdt_pkg.sv
// Contract
// - a write of eight bits to port 443h arms the timer with that timeout; the code disarms instead on a write of 00h
// - the written code counts linearly as whole seconds, 01h..ffh gives 1..255 s
// - each rewrite of port 443h reloads the count and restarts the timeout
// - a read of port 043h disables the timer; no expiry until rewritten
package wdt_pkg;
  localparam logic [15:0] DISABLE_PORT = 16'h0043;
  localparam logic [15:0] LOAD_PORT = 16'h0443;
  localparam int CLK_HZ = 100000000;
  localparam int SEC_MS = 1000;
  // one tick is one whole second of the system clock
  localparam int TICK_CYCLES = CLK_HZ;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] RD_DATA_IDLE = 8'h00;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } io_req_t;
endpackage
